// ==== logic/spp_port.sv ====
// Serial programming port: entry detection, command framing, handshake
`timescale 1ns/100ps
module spp_port #(
  parameter int FIFO_DEPTH_P = spp_pkg::FIFO_DEPTH
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  por_busy,
  input  wire logic                  ext_reset_pin_n,
  input  wire logic                  prog_clock_pin,
  input  wire logic                  latch_pin,
  input  wire logic                  command_pin,
  output logic                       response_pin,
  output logic                       response_pin_oe,
  output logic                       program_mode,
  output logic                       normal_run,
  output logic                       status_write_done,
  output logic                       mem_req_valid,
  output spp_pkg::spp_cmd_t          mem_req,
  input  wire logic                  mem_req_ready,
  input  wire logic                  mem_rsp_valid,
  input  wire spp_pkg::spp_mem_rsp_t mem_rsp
);
  import spp_pkg::*;

  // --------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------
  // sampled bit must be settled in time
  if (SYNC_LAT > ACCESS_CYC) begin : g_slow
    $error("spp_port: clock too slow for the response access time");
  end
  if (FIFO_DEPTH_P < 2) begin : g_depth
    $error("spp_port: command FIFO needs at least two words");
  end
  if ($bits(spp_cmd_t) != CMD_W) begin : g_word
    $error("spp_port: command carrier must match the frame width");
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WINDOW,   // Reset interval, entry pattern may arrive
    ST_NORMAL,   // Normal program execution
    ST_SHIFT,    // Latch high, command frame shifting
    ST_EXEC,     // Latch low, counting the two start pulses
    ST_PUSH,     // Handing the command to memory
    ST_WAIT,     // Memory working, response held low
    ST_DONE      // Response high, waiting for next latch rise
  } spp_phase_t;

  typedef struct packed {
    spp_phase_t         phase;
    logic [1:0]         clk_sync;
    logic               clk_prev;
    logic [1:0]         latch_sync;
    logic               latch_prev;
    logic [1:0]         din_sync;
    logic [1:0]         rstpin_sync;
    logic [ENTRY_W-1:0] entry_sh;
    logic               armed;
    logic [5:0]         bit_cnt;
    logic [1:0]         low_edges;
    logic [CMD_W-1:0]   cmd_sh;
    logic [CMD_W-1:0]   resp_sh;
    logic               resp_out;
    logic               prog_mode;
    logic               wr_done;
    spp_cmd_t           cur;
  } spp_port_st_t;

  spp_port_st_t q;
  spp_port_st_t nxt_q;

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  // response echoes address, carries the data byte
  function automatic logic [CMD_W-1:0] build_resp(
    input spp_cmd_t          c,
    input logic [DATA_W-1:0] d
  );
    spp_cmd_t r;
    r      = '0;
    r.addr = c.addr;
    r.data = d;
    return r;
  endfunction : build_resp

  // exactly one memory selected, reserved bits zero
  function automatic logic cmd_legal(input spp_cmd_t c);
    return (c.zero_hi == '0) && (c.zero_mid == '0) &&
           (c.zero_lo == '0) && (c.sel_data ^ c.sel_code);
  endfunction : cmd_legal

  // Frame has taken all of its bits
  function automatic logic frame_full(input logic [5:0] n);
    return n == BITS_FULL;
  endfunction : frame_full

  // Edge decode shared by the link clock and the latch
  function automatic logic rise_of(input logic lvl, input logic prv);
    return lvl & ~prv;
  endfunction : rise_of

  function automatic logic fall_of(input logic lvl, input logic prv);
    return ~lvl & prv;
  endfunction : fall_of

  // --------------------------------------------------------------
  // Edge detection on the synchronised link
  // --------------------------------------------------------------
  logic     clk_rise;
  logic     latch_rise;
  logic     latch_fall;
  logic     latch_hi;
  logic     din;
  logic     pin_released;
  logic     entry_match;
  spp_cmd_t frame;

  // Decode reads the second flop of each synchroniser only
  assign clk_rise     = rise_of(q.clk_sync[1], q.clk_prev);
  assign latch_hi     = q.latch_sync[1];
  assign latch_rise   = rise_of(q.latch_sync[1], q.latch_prev);
  assign latch_fall   = fall_of(q.latch_sync[1], q.latch_prev);
  assign din          = q.din_sync[1];
  assign pin_released = q.rstpin_sync[1];
  assign entry_match  = (q.entry_sh == ENTRY_CODE);
  assign frame        = q.cmd_sh;

  // --------------------------------------------------------------
  // Command FIFO towards the memory side
  // --------------------------------------------------------------
  // One command in flight at a time; depth is headroom for the memory side
  logic     fifo_in_valid;
  logic     fifo_in_ready;
  spp_cmd_t fifo_out;

  spp_fifo #(
    .W     (CMD_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (q.cur),
    .out_valid (mem_req_valid),
    .out_ready (mem_req_ready),
    .out_data  (fifo_out)
  );

  assign mem_req = fifo_out;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    // Hold state, no push unless a phase asks
    nxt_q         = q;
    fifo_in_valid = 1'b0;

    // link clock, latch, command and reset pins pass two flops
    nxt_q.clk_sync    = {q.clk_sync[0], prog_clock_pin};
    nxt_q.latch_sync  = {q.latch_sync[0], latch_pin};
    nxt_q.din_sync    = {q.din_sync[0], command_pin};
    nxt_q.rstpin_sync = {q.rstpin_sync[0], ext_reset_pin_n};

    // Previous levels for edge decode
    nxt_q.clk_prev    = q.clk_sync[1];
    nxt_q.latch_prev  = q.latch_sync[1];

    // Phase sequence of the link
    case (q.phase)
      ST_WINDOW: begin
        // no shifting while reset pin held low
        if (clk_rise && pin_released) begin
          // MSB first on each clock rise
          nxt_q.entry_sh = {q.entry_sh[ENTRY_W-2:0], din};
        end
        // Armed keeps a match that later bits would shift out
        // match arms program mode
        if (entry_match) begin
          nxt_q.armed = 1'b1;
        end
        if (!por_busy && pin_released) begin
          if (q.armed || entry_match) begin
            nxt_q.prog_mode = 1'b1;
            nxt_q.resp_out  = 1'b1;
            nxt_q.phase     = ST_DONE;
          end else begin
            nxt_q.phase = ST_NORMAL;
          end
        end
      end

      ST_NORMAL: begin
        // Shifter cleared so stale bits cannot match
        // a new reset reopens the entry window
        if (por_busy || !pin_released) begin
          nxt_q.entry_sh = '0;
          nxt_q.armed    = 1'b0;
          nxt_q.phase    = ST_WINDOW;
        end
      end

      ST_DONE: begin
        // High is both idle level and done handshake
        nxt_q.resp_out = 1'b1;
        // next frame only after response high
        if (latch_rise) begin
          nxt_q.bit_cnt = '0;
          nxt_q.wr_done = 1'b0;
          nxt_q.phase   = ST_SHIFT;
        end
      end

      ST_SHIFT: begin
        if (latch_rise) begin
          nxt_q.bit_cnt = '0;
        end else if (clk_rise && latch_hi) begin
          nxt_q.cmd_sh = {q.cmd_sh[CMD_W-2:0], din};
          nxt_q.resp_out = q.resp_sh[CMD_W-1];
          nxt_q.resp_sh  = {q.resp_sh[CMD_W-2:0], 1'b0};
          // Saturates, so extra bits keep the last 32
          if (!frame_full(q.bit_cnt)) begin
            nxt_q.bit_cnt = q.bit_cnt + 1'b1;
          end
        end
        if (latch_fall) begin
          if (frame_full(q.bit_cnt)) begin
            nxt_q.low_edges = '0;
            nxt_q.phase     = ST_EXEC;
          end else begin
            nxt_q.phase = ST_DONE;
          end
        end
      end

      ST_EXEC: begin
        // Rises after the second find this phase gone
        if (clk_rise) begin
          nxt_q.low_edges = q.low_edges + 1'b1;
          if (q.low_edges == EXEC_EDGE) begin
            nxt_q.resp_out = 1'b0;
            nxt_q.cur      = frame;
            if (cmd_legal(frame)) begin
              nxt_q.phase = ST_PUSH;
            end else begin
              nxt_q.resp_sh = build_resp(frame, NO_DATA);
              nxt_q.phase   = ST_DONE;
            end
          end
        end
      end

      ST_PUSH: begin
        // Stalls here while the FIFO is full
        fifo_in_valid = 1'b1;
        if (fifo_in_ready) begin
          nxt_q.phase = ST_WAIT;
        end
      end

      ST_WAIT: begin
        // One command outstanding, so the answer is for cur
        if (mem_rsp_valid) begin
          // read byte into low eight bits
          nxt_q.resp_sh = build_resp(q.cur, mem_rsp.data);
          if (!q.cur.is_read) begin
            nxt_q.wr_done = 1'b1;
          end
          nxt_q.resp_out = 1'b1;
          nxt_q.phase    = ST_DONE;
        end
      end

      default: begin
        nxt_q.phase = ST_WINDOW;
      end
    endcase
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset leaves the pin low and undriven
  // only a power reset leaves program mode
  // first response is whatever is in the shifter
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Levels taken straight from the state register
  assign response_pin      = q.resp_out;
  assign response_pin_oe   = q.prog_mode;  // Driven only in program mode
  assign program_mode      = q.prog_mode;
  assign normal_run        = (q.phase == ST_NORMAL);
  assign status_write_done = q.wr_done;

endmodule : spp_port

// ==== logic/spp_pkg.sv ====
// Shared constants and carriers for the serial programming port
package spp_pkg;

  // --------------------------------------------------------------
  // Link word layout and entry code
  // --------------------------------------------------------------
  localparam int          CMD_W      = 32;
  localparam int          ENTRY_W    = 10;
  localparam logic [9:0]  ENTRY_CODE = 10'h34B;
  localparam int          ADDR_W     = 11;
  localparam int          DATA_W     = 8;
  localparam logic [5:0]  BITS_FULL  = 6'h20;  // Bits in one command frame
  localparam logic [1:0]  EXEC_EDGE  = 2'h1;   // Index of second low-latch edge
  localparam logic [7:0]  NO_DATA    = 8'h00;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_ACCESS_NS   = 500;
  // Longest time, so rounded down
  localparam int ACCESS_CYC    = T_ACCESS_NS / CLK_PERIOD_NS;
  // Pin to response pin latency: two sync stages, edge flop, output flop
  localparam int SYNC_LAT      = 4;
  localparam int FIFO_DEPTH    = 16;

  // --------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------
  // Command word, bit 31 first on the wire
  typedef struct packed {
    logic [1:0]        zero_hi;
    logic              sel_data;   // Data EEPROM or init registers
    logic              sel_code;   // Code EEPROM
    logic [2:0]        zero_mid;
    logic              is_read;
    logic [4:0]        zero_lo;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } spp_cmd_t;

  // Memory answer to one command
  typedef struct packed {
    logic [DATA_W-1:0] data;
  } spp_mem_rsp_t;

endpackage : spp_pkg

// ==== logic/spp_fifo.sv ====
// Small synchronous FIFO with a registered read stage
`timescale 1ns/100ps
module spp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // --------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad
    $error("spp_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic                    ov;
    logic [W-1:0]            od;
  } spp_fifo_st_t;

  spp_fifo_st_t q;
  spp_fifo_st_t nxt_q;
  logic         push;
  logic         load;

  // Push, refill of output stage and occupancy
  always_comb begin
    nxt_q    = q;
    in_ready = (q.count != DEPTH[AW:0]);
    push     = in_valid & in_ready;
    load     = (q.count != '0) & (~q.ov | out_ready);
    if (push) begin
      nxt_q.mem[q.wr_ptr] = in_data;
      nxt_q.wr_ptr        = q.wr_ptr + 1'b1;
    end
    if (load) begin
      nxt_q.od     = q.mem[q.rd_ptr];
      nxt_q.ov     = 1'b1;
      nxt_q.rd_ptr = q.rd_ptr + 1'b1;
    end else if (out_ready) begin
      nxt_q.ov = 1'b0;
    end
    if (push && !load) begin
      nxt_q.count = q.count + 1'b1;
    end else if (load && !push) begin
      nxt_q.count = q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  assign out_valid = q.ov;
  assign out_data  = q.od;

endmodule : spp_fifo

// ==== tb/spp_port_props.sv ====
// Checker of the programming port outputs
`timescale 1ns/100ps
module spp_port_props
  import spp_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic          clock,
  input wire logic          reset,
  input wire logic          por_busy,
  input wire logic          ext_reset_pin_n,
  input wire logic          prog_clock_pin,
  input wire logic          latch_pin,
  input wire logic          command_pin,
  input wire logic          response_pin,
  input wire logic          response_pin_oe,
  input wire logic          program_mode,
  input wire logic          normal_run,
  input wire logic          status_write_done,
  input wire logic          mem_req_valid,
  input wire spp_cmd_t      mem_req,
  input wire logic          mem_req_ready,
  input wire logic          mem_rsp_valid,
  input wire spp_mem_rsp_t  mem_rsp
);
  // ----------------------------------------------------------------
  // Output relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_OE_MODE: assert property (response_pin_oe == program_mode)
    else $error("response enable differs from program mode");
  AST_MODE_HOLD: assert property (!$fell(program_mode))
    else $error("program mode left without reset");
  AST_MODE_EXCL: assert property (!(program_mode && normal_run))
    else $error("program mode and normal run together");
  AST_ENTRY_END: assert property ($rose(program_mode) |-> $past(!por_busy))
    else $error("program mode entered inside reset window");
  AST_REQ_MODE: assert property (mem_req_valid |-> program_mode)
    else $error("memory request outside program mode");
  AST_REQ_HOLD: assert property (mem_req_valid && !mem_req_ready |=>
      mem_req_valid && $stable(mem_req))
    else $error("memory request changed while stalled");
  AST_REQ_LEGAL: assert property (mem_req_valid |-> mem_req.zero_hi == 2'h0 &&
      mem_req.zero_mid == 3'h0 && mem_req.zero_lo == 5'h00 &&
      (mem_req.sel_data ^ mem_req.sel_code))
    else $error("illegal command forwarded");
  AST_DONE_SRC: assert property ($rose(status_write_done) |-> $past(mem_rsp_valid))
    else $error("write done without memory answer");
  AST_RSP_HIGH: assert property (mem_rsp_valid && program_mode |=> response_pin)
    else $error("response not released after answer");
  AST_BUSY_LOW: assert property ($rose(mem_req_valid) |-> !response_pin)
    else $error("response high while request outstanding");
endmodule : spp_port_props

bind spp_port spp_port_props #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) spp_port_props_inst (
  .clock(clock), .reset(reset), .por_busy(por_busy),
  .ext_reset_pin_n(ext_reset_pin_n), .prog_clock_pin(prog_clock_pin),
  .latch_pin(latch_pin), .command_pin(command_pin), .response_pin(response_pin),
  .response_pin_oe(response_pin_oe), .program_mode(program_mode),
  .normal_run(normal_run), .status_write_done(status_write_done),
  .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
  .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp)
);

// ==== tb/spp_prog_model.sv ====
// Programmer model driving the four-wire link
`timescale 1ns/100ps
module spp_prog_model (
  output logic     prog_clock_pin,
  output logic     latch_pin,
  output logic     command_pin,
  input wire logic response_pin
);
  // Link clock stands low outside frames
  initial begin
    prog_clock_pin = 1'b0;
    latch_pin = 1'b0;
    command_pin = 1'b0;
  end

  // bit set before rise, answer sampled late
  task automatic bits(input logic [31:0] v, input int n, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      command_pin = v[i];
      #20 prog_clock_pin = 1'b1;
      #80 prog_clock_pin = 1'b0;
      #50 r = {r[30:0], response_pin};
      #10;
    end
  endtask : bits

  // latch low, two pulses, wait for release
  task automatic frame(input logic [31:0] cmd, input int n,
                       output logic [31:0] r, output logic busy);
    logic [31:0] x;
    latch_pin = 1'b1;
    #60;
    bits(cmd, n, r);
    latch_pin = 1'b0;
    #60;
    bits(32'h0, 2, x);
    busy = x[0];
    for (int k = 0; k < 300 && response_pin !== 1'b1; k++) #20;
    #40;
  endtask : frame
endmodule : spp_prog_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the programming port
`timescale 1ns/100ps
module tb_top;
  import spp_pkg::*;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         por_busy = 1'b0;
  logic         ext_reset_pin_n = 1'b1;
  logic         mem_req_ready = 1'b1;
  logic         mem_rsp_valid = 1'b0;
  spp_mem_rsp_t mem_rsp = '0;
  logic         prog_clock_pin, latch_pin, command_pin, response_pin, response_pin_oe;
  logic         program_mode, normal_run, status_write_done, mem_req_valid;
  spp_cmd_t     mem_req, hold;
  logic [7:0]   mem [0:2047];
  logic [31:0]  r;
  logic         b;
  int           error_cnt = 0;
  int           n_tests = 0;
  int           mem_ops = 0;
  int           cnt = 0;

  initial forever #10 clock = ~clock;

  spp_port spp_port_inst (.clock(clock), .reset(reset), .por_busy(por_busy),
    .ext_reset_pin_n(ext_reset_pin_n), .prog_clock_pin(prog_clock_pin),
    .latch_pin(latch_pin), .command_pin(command_pin), .response_pin(response_pin),
    .response_pin_oe(response_pin_oe), .program_mode(program_mode),
    .normal_run(normal_run), .status_write_done(status_write_done),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp(mem_rsp));
  spp_prog_model spp_prog_model_inst (.prog_clock_pin(prog_clock_pin),
    .latch_pin(latch_pin), .command_pin(command_pin), .response_pin(response_pin));

  // Memory side: accepts one request, answers five clocks later
  always @(posedge clock) begin
    mem_rsp_valid <= 1'b0;
    if (cnt == 1) begin
      mem_rsp_valid <= 1'b1;
      mem_rsp.data <= hold.is_read ? mem[hold.addr] : hold.data;
      if (!hold.is_read) mem[hold.addr] <= hold.data;
      mem_ops <= mem_ops + 1;
    end
    if (cnt > 0) cnt <= cnt - 1;
    else if (mem_req_valid && mem_req_ready) begin
      hold <= mem_req;
      cnt <= 5;
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Bad code runs normally; pin reset reopens window for good code
  task automatic t_entry;
    por_busy = 1'b1;
    step(2);
    spp_prog_model_inst.bits(32'h34A, 10, r);
    step(1);
    por_busy = 1'b0;
    step(6);
    chk(normal_run, 1'b1);
    chk(program_mode, 1'b0);
    ext_reset_pin_n = 1'b0;
    step(4);
    por_busy = 1'b1;
    ext_reset_pin_n = 1'b1;
    step(4);
    spp_prog_model_inst.bits(32'h2F4B, 14, r);
    step(1);
    por_busy = 1'b0;
    step(6);
    chk(program_mode, 1'b1);
    chk(response_pin_oe, 1'b1);
    chk(response_pin, 1'b1);
  endtask : t_entry

  // Write, then stalled read, illegal and short frames, then write
  task automatic t_cmds;
    spp_prog_model_inst.frame(32'h200123A5, 32, r, b);
    chk(b, 1'b0);
    chk(response_pin, 1'b1);
    chk(status_write_done, 1'b1);
    chk(hold, 32'h200123A5);
    // Memory refuses until well after the read request stands
    fork
      begin
        mem_req_ready = 1'b0;
        #6000 mem_req_ready = 1'b1;
      end
    join_none
    spp_prog_model_inst.frame(32'h11012300, 32, r, b);
    chk(r, 32'h000123A5);
    chk(b, 1'b0);
    chk(response_pin, 1'b1);
    chk(status_write_done, 1'b0);
    spp_prog_model_inst.frame(32'h30012300, 32, r, b);
    chk(r, 32'h000123A5);
    spp_prog_model_inst.frame(32'hA0012300, 32, r, b);
    chk(r, 32'h00012300);
    chk(mem_ops, 2);
    spp_prog_model_inst.frame(32'h200456C3, 31, r, b);
    chk(r, 32'h00009180);
    spp_prog_model_inst.frame(32'h2004563C, 32, r, b);
    chk(mem_ops, 3);
    chk(hold, 32'h2004563C);
    chk(mem[11'h456], 8'h3C);
  endtask : t_cmds

  // Only reset clears program mode
  task automatic t_power;
    chk(program_mode, 1'b1);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
    chk(program_mode, 1'b0);
  endtask : t_power

  initial begin
    step(12);
    reset = 1'b0;
    step(1);
    t_entry();
    t_cmds();
    t_power();
    results();
  end

  // Watchdog
  initial begin
    #500000;
    error_cnt++;
    results();
  end
endmodule : tb_top
